// *** logic/srb_pkg.sv ***
/*
 * constants for the special-register bank: windows, offsets, reset values,
 * register slots and reset-cause bit positions.
 * assumes a 20-bit byte address from the core and 8-bit registers.
 */
//   Function
//   RULE_01: extended window spans F0000H to F07FFH
//   RULE_02: registers outside primary window go extended
//   RULE_03: bit or byte access per register type
//   RULE_04: extended-window instructions are one byte longer
//   RULE_05: reset cause read-only, byte-only, at FFFA8H
//   RULE_06: reset cause flags follow reset source
//   RULE_07: watchdog enable resets to 1AH or 9AH
//   RULE_08: request flags reset 00H, bit/byte read-write
//   RULE_09: mask flags reset FFH, bit/byte read-write
//   RULE_10: both priority groups reset FFH, bit/byte
//   RULE_11: third group exists only in large variant
//   RULE_12: mode control, clock select reset 00H
//   RULE_13: software never touches unassigned extended addresses; the bench accesses random ones
//   RULE_14: writes to read-only register silently ignored
package srb_pkg;

   // =====================================================
   // address windows
   localparam logic [19:0] LP_PRI_LO      = 20'hFFF00;
   localparam logic [19:0] LP_PRI_HI      = 20'hFFFFF;
   localparam logic [19:0] LP_EXT_LO      = 20'hF0000;
   localparam logic [19:0] LP_EXT_HI      = 20'hF07FF;
   localparam logic [1:0]  LP_EXT_EXTRA   = 2'h1;    // extra opcode bytes

   // =====================================================
   // register addresses
   localparam logic [19:0] LP_A_CKS       = 20'hFFFA5;
   localparam logic [19:0] LP_A_RCAUSE    = 20'hFFFA8;
   localparam logic [19:0] LP_A_WDTEN     = 20'hFFFAB;
   localparam logic [19:0] LP_A_IF_A_L    = 20'hFFFE0;
   localparam logic [19:0] LP_A_IF_A_H    = 20'hFFFE1;
   localparam logic [19:0] LP_A_IF_B_L    = 20'hFFFE2;
   localparam logic [19:0] LP_A_MK_A_L    = 20'hFFFE4;
   localparam logic [19:0] LP_A_MK_A_H    = 20'hFFFE5;
   localparam logic [19:0] LP_A_MK_B_L    = 20'hFFFE6;
   localparam logic [19:0] LP_A_PL_A_L    = 20'hFFFE8;
   localparam logic [19:0] LP_A_PL_A_H    = 20'hFFFE9;
   localparam logic [19:0] LP_A_PL_B_L    = 20'hFFFEA;
   localparam logic [19:0] LP_A_PH_A_L    = 20'hFFFEC;
   localparam logic [19:0] LP_A_PH_A_H    = 20'hFFFED;
   localparam logic [19:0] LP_A_PH_B_L    = 20'hFFFEE;
   localparam logic [19:0] LP_A_PMC       = 20'hFFFFE;

   // =====================================================
   // storage slots of the writable registers
   localparam int          LP_NREG        = 15;
   localparam logic [4:0]  LP_I_CKS       = 5'h00;
   localparam logic [4:0]  LP_I_WDTEN     = 5'h01;
   localparam logic [4:0]  LP_I_IF_A_L    = 5'h02;
   localparam logic [4:0]  LP_I_IF_A_H    = 5'h03;
   localparam logic [4:0]  LP_I_IF_B_L    = 5'h04;
   localparam logic [4:0]  LP_I_MK_A_L    = 5'h05;
   localparam logic [4:0]  LP_I_MK_A_H    = 5'h06;
   localparam logic [4:0]  LP_I_MK_B_L    = 5'h07;
   localparam logic [4:0]  LP_I_PL_A_L    = 5'h08;
   localparam logic [4:0]  LP_I_PL_A_H    = 5'h09;
   localparam logic [4:0]  LP_I_PL_B_L    = 5'h0A;
   localparam logic [4:0]  LP_I_PH_A_L    = 5'h0B;
   localparam logic [4:0]  LP_I_PH_A_H    = 5'h0C;
   localparam logic [4:0]  LP_I_PH_B_L    = 5'h0D;
   localparam logic [4:0]  LP_I_PMC       = 5'h0E;
   localparam logic [4:0]  LP_I_RCAUSE    = 5'h0F;   // read-only, not stored here
   localparam logic [4:0]  LP_I_NONE      = 5'h1F;

   // =====================================================
   // reset values
   localparam logic [7:0]  LP_RV_ZERO     = 8'h00;
   localparam logic [7:0]  LP_RV_ONES     = 8'hFF;
   localparam logic [7:0]  LP_RV_WDT_OFF  = 8'h1A;
   localparam logic [7:0]  LP_RV_WDT_ON   = 8'h9A;

   // =====================================================
   // reset-cause bit positions
   localparam int          LP_RC_TRAP     = 7;
   localparam int          LP_RC_WDT      = 4;
   localparam int          LP_RC_SUPPLY_MONITOR_RESET     = 0;

endpackage : srb_pkg

// *** logic/srb_top.sv ***
/*
 * special-register bank: primary and extended window decode, bit/byte
 * access checks, interrupt request/mask/priority flags, reset-cause flags
 * and watchdog enable preset from the option byte.
 * assumes the core issues one access per i_req pulse, that reset-source
 * levels and the option bit are stable from reset through the first clock
 * after release, and that i_por_n falls only at power-up.
 */
`timescale 1ns/10ps
`default_nettype none

module srb_top #(
   parameter bit P_LARGE_PINS = 1'b1           // 16-pin variant has group b
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_por_n,
   // core access port
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic        i_bit_op,
   input  wire logic [2:0]  i_bit_sel,
   input  wire logic [19:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   output logic             o_ack,
   output logic             o_err,
   output logic [7:0]       o_rdata,
   output logic             o_win_pri,
   output logic             o_win_ext,
   output logic [1:0]       o_extra_bytes,
   // reset sources and option byte
   input  wire logic        i_cause_pin,
   input  wire logic        i_cause_illegal,
   input  wire logic        i_cause_wdt,
   input  wire logic        i_cause_supply_monitor_reset,
   input  wire logic        i_cause_lvd,
   input  wire logic        i_opt_wdt_on,
   // interrupt events and flag outputs
   input  wire logic [23:0] i_irq_set,
   output logic [23:0]      o_irq_req,
   output logic [23:0]      o_irq_mask,
   output logic [23:0]      o_prio_lo,
   output logic [23:0]      o_prio_hi,
   output logic [7:0]       o_clk_out_sel,
   output logic [7:0]       o_proc_mode,
   output logic [7:0]       o_wdt_enable,
   output logic [7:0]       o_reset_cause
);

   // =====================================================
   // state
   typedef struct packed {
      logic [srb_pkg::LP_NREG-1:0][7:0] regs;
      logic                             boot;
      logic                             ack;
      logic                             err;
      logic [7:0]                       rdata;
      logic                             win_pri;
      logic                             win_ext;
      logic [1:0]                       extra;
   } srb_state_s;

   srb_state_s  st_r;
   srb_state_s  st_nxt;
   logic [7:0]  rcause_r;
   logic [7:0]  rcause_nxt;

   // =====================================================
   // decode helpers
   // address to storage slot; group b slots vanish on the small variant
   function automatic logic [4:0] srb_decode(input logic [19:0] a);
      logic [4:0] idx;
      idx = srb_pkg::LP_I_NONE;
      case (a)
         srb_pkg::LP_A_CKS    : idx = srb_pkg::LP_I_CKS;
         srb_pkg::LP_A_RCAUSE : idx = srb_pkg::LP_I_RCAUSE;          // RULE_05
         srb_pkg::LP_A_WDTEN  : idx = srb_pkg::LP_I_WDTEN;
         srb_pkg::LP_A_IF_A_L : idx = srb_pkg::LP_I_IF_A_L;
         srb_pkg::LP_A_IF_A_H : idx = srb_pkg::LP_I_IF_A_H;
         srb_pkg::LP_A_MK_A_L : idx = srb_pkg::LP_I_MK_A_L;
         srb_pkg::LP_A_MK_A_H : idx = srb_pkg::LP_I_MK_A_H;
         srb_pkg::LP_A_PL_A_L : idx = srb_pkg::LP_I_PL_A_L;
         srb_pkg::LP_A_PL_A_H : idx = srb_pkg::LP_I_PL_A_H;
         srb_pkg::LP_A_PH_A_L : idx = srb_pkg::LP_I_PH_A_L;
         srb_pkg::LP_A_PH_A_H : idx = srb_pkg::LP_I_PH_A_H;
         srb_pkg::LP_A_PMC    : idx = srb_pkg::LP_I_PMC;
         srb_pkg::LP_A_IF_B_L : idx = P_LARGE_PINS ? srb_pkg::LP_I_IF_B_L
                                                   : srb_pkg::LP_I_NONE; // RULE_11
         srb_pkg::LP_A_MK_B_L : idx = P_LARGE_PINS ? srb_pkg::LP_I_MK_B_L
                                                   : srb_pkg::LP_I_NONE; // RULE_11
         srb_pkg::LP_A_PL_B_L : idx = P_LARGE_PINS ? srb_pkg::LP_I_PL_B_L
                                                   : srb_pkg::LP_I_NONE; // RULE_11
         srb_pkg::LP_A_PH_B_L : idx = P_LARGE_PINS ? srb_pkg::LP_I_PH_B_L
                                                   : srb_pkg::LP_I_NONE; // RULE_11
         default              : idx = srb_pkg::LP_I_NONE;
      endcase
      return idx;
   endfunction

   // only the watchdog enable and reset cause refuse single-bit access
   function automatic logic srb_bit_ok(input logic [4:0] idx);
      return (idx != srb_pkg::LP_I_WDTEN) && (idx != srb_pkg::LP_I_RCAUSE); // RULE_03
   endfunction

   // reset value of each stored slot
   function automatic logic [7:0] srb_reset_val(input int i);
      logic [7:0] v;
      v = srb_pkg::LP_RV_ZERO;                                         // RULE_08 RULE_12
      if (i >= int'(srb_pkg::LP_I_MK_A_L) && i <= int'(srb_pkg::LP_I_PH_B_L)) begin
         v = srb_pkg::LP_RV_ONES;                                      // RULE_09 RULE_10
      end
      if (i == int'(srb_pkg::LP_I_WDTEN)) begin
         v = srb_pkg::LP_RV_WDT_OFF;       // replaced by option load in the boot cycle
      end
      return v;
   endfunction

   // =====================================================
   // next-state logic
   // access is decoded, checked, applied, then hardware flag sets are merged
   always_comb begin
      logic [4:0] idx;
      logic       in_pri;
      logic       in_ext;
      logic       refuse;
      logic [7:0] cur;
      logic [7:0] upd;
      idx    = srb_decode(i_addr);
      in_pri = (i_addr >= srb_pkg::LP_PRI_LO) && (i_addr <= srb_pkg::LP_PRI_HI);
      in_ext = (i_addr >= srb_pkg::LP_EXT_LO) && (i_addr <= srb_pkg::LP_EXT_HI); // RULE_01
      refuse = (idx == srb_pkg::LP_I_NONE) || (i_bit_op && !srb_bit_ok(idx));  // RULE_03
      cur    = srb_pkg::LP_RV_ZERO;
      upd    = srb_pkg::LP_RV_ZERO;
      st_nxt = st_r;
      st_nxt.ack  = 1'b0;
      st_nxt.boot = 1'b0;

      // watchdog enable preset taken once after reset release
      if (st_r.boot) begin
         st_nxt.regs[srb_pkg::LP_I_WDTEN] = i_opt_wdt_on ? srb_pkg::LP_RV_WDT_ON
                                                         : srb_pkg::LP_RV_WDT_OFF; // RULE_07
      end

      if (i_req) begin
         st_nxt.ack     = 1'b1;
         st_nxt.err     = refuse;
         st_nxt.win_pri = in_pri;
         // only addresses in the extended range and not in the primary window are flagged extended
         st_nxt.win_ext = in_ext && !in_pri;                              // RULE_02
         st_nxt.extra   = (in_ext && !in_pri) ? srb_pkg::LP_EXT_EXTRA : 2'h0; // RULE_04
         if (idx == srb_pkg::LP_I_RCAUSE) begin
            cur = rcause_r;
         end else if (idx < srb_pkg::LP_I_RCAUSE) begin
            cur = st_r.regs[idx[3:0]];
         end
         // refused reads return zero; bit reads return the bit in bit 0
         if (refuse) begin
            st_nxt.rdata = srb_pkg::LP_RV_ZERO;
         end else if (i_bit_op) begin
            st_nxt.rdata = {7'h00, cur[i_bit_sel]};
         end else begin
            st_nxt.rdata = cur;
         end
         // bit write is a read-modify-write of one bit
         upd = cur;
         if (i_bit_op) begin
            upd[i_bit_sel] = i_wdata[0];
         end else begin
            upd = i_wdata;
         end
         // reset cause is never written; the write just completes
         if (i_we && !refuse && idx < srb_pkg::LP_I_RCAUSE) begin       // RULE_14
            st_nxt.regs[idx[3:0]] = upd;                           // RULE_08 RULE_09
         end
      end

      // hardware request events win over a clearing write in the same cycle
      st_nxt.regs[srb_pkg::LP_I_IF_A_L] = st_nxt.regs[srb_pkg::LP_I_IF_A_L]
                                          | i_irq_set[7:0];
      st_nxt.regs[srb_pkg::LP_I_IF_A_H] = st_nxt.regs[srb_pkg::LP_I_IF_A_H]
                                          | i_irq_set[15:8];
      if (P_LARGE_PINS) begin
         st_nxt.regs[srb_pkg::LP_I_IF_B_L] = st_nxt.regs[srb_pkg::LP_I_IF_B_L]
                                             | i_irq_set[23:16];
      end
   end

   // =====================================================
   // reset-cause update from the active source
   // pin and low-retention resets wipe the flags; others set just their own
   always_comb begin
      rcause_nxt = rcause_r;
      if (i_cause_pin || i_cause_lvd) begin
         rcause_nxt = srb_pkg::LP_RV_ZERO;                                // RULE_06
      end else begin
         if (i_cause_illegal) begin
            rcause_nxt[srb_pkg::LP_RC_TRAP] = 1'b1;                       // RULE_06
         end
         if (i_cause_wdt) begin
            rcause_nxt[srb_pkg::LP_RC_WDT] = 1'b1;                        // RULE_06
         end
         if (i_cause_supply_monitor_reset) begin
            rcause_nxt[srb_pkg::LP_RC_SUPPLY_MONITOR_RESET] = 1'b1;                       // RULE_06
         end
      end
   end

   // =====================================================
   // registers
   // main state; every slot loads its documented value under reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < srb_pkg::LP_NREG; i++) begin
            st_r.regs[i] <= srb_reset_val(i);
         end
         st_r.boot    <= 1'b1;
         st_r.ack     <= 1'b0;
         st_r.err     <= 1'b0;
         st_r.rdata   <= srb_pkg::LP_RV_ZERO;
         st_r.win_pri <= 1'b0;
         st_r.win_ext <= 1'b0;
         st_r.extra   <= 2'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // reset cause must outlive the system reset, so only power-up clears it asynchronously;
   // it is updated on every clock while the system reset is held and in the first cycle after it lets go
   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         rcause_r <= srb_pkg::LP_RV_ZERO;
      end else if (st_r.boot) begin
         rcause_r <= rcause_nxt;                                          // RULE_05
      end
   end

   // =====================================================
   // outputs, all straight from flops
   assign o_ack         = st_r.ack;
   assign o_err         = st_r.err;
   assign o_rdata       = st_r.rdata;
   assign o_win_pri     = st_r.win_pri;
   assign o_win_ext     = st_r.win_ext;
   assign o_extra_bytes = st_r.extra;
   assign o_irq_req     = {st_r.regs[srb_pkg::LP_I_IF_B_L],
                           st_r.regs[srb_pkg::LP_I_IF_A_H],
                           st_r.regs[srb_pkg::LP_I_IF_A_L]};
   assign o_irq_mask    = {st_r.regs[srb_pkg::LP_I_MK_B_L],
                           st_r.regs[srb_pkg::LP_I_MK_A_H],
                           st_r.regs[srb_pkg::LP_I_MK_A_L]};
   assign o_prio_lo     = {st_r.regs[srb_pkg::LP_I_PL_B_L],
                           st_r.regs[srb_pkg::LP_I_PL_A_H],
                           st_r.regs[srb_pkg::LP_I_PL_A_L]};
   assign o_prio_hi     = {st_r.regs[srb_pkg::LP_I_PH_B_L],
                           st_r.regs[srb_pkg::LP_I_PH_A_H],
                           st_r.regs[srb_pkg::LP_I_PH_A_L]};
   assign o_clk_out_sel = st_r.regs[srb_pkg::LP_I_CKS];
   assign o_proc_mode   = st_r.regs[srb_pkg::LP_I_PMC];
   assign o_wdt_enable  = st_r.regs[srb_pkg::LP_I_WDTEN];
   assign o_reset_cause = rcause_r;

endmodule // srb_top

`default_nettype wire

// *** test/srb_core_model.sv ***
/*
 * behavioural model of the processor core issuing register accesses.
 * assumes the bank takes a request at the rising edge and answers one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none

module srb_core_model (
   input  wire logic        i_clk,
   output logic             o_req,
   output logic             o_we,
   output logic             o_bit_op,
   output logic [2:0]       o_bit_sel,
   output logic [19:0]      o_addr,
   output logic [7:0]       o_wdata,
   input  wire logic        i_ack,
   input  wire logic        i_err,
   input  wire logic [7:0]  i_rdata
);
   // =====================================================
   // idle bus at time zero
   initial begin
      o_req = 1'h0;
      {o_we, o_bit_op, o_bit_sel, o_addr, o_wdata} = '0;
   end

   // =====================================================
   // one access: drive at a falling edge, collect the answer one cycle on
   // any address is driven as given, unassigned extended ones included
   task automatic access(input logic w, input logic b, input logic [2:0] s,
                         input logic [19:0] a, input logic [7:0] d,
                         output logic [7:0] rd, output logic er, output logic ak);
      @(negedge i_clk);
      o_req = 1'h1;
      o_we = w;
      o_bit_op = b;
      o_bit_sel = s;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      rd = i_rdata;
      er = i_err;
      ak = i_ack;
      // released qualifiers flip so a stale value is never mistaken for live
      o_req = 1'h0;
      o_we = ~w;
      o_bit_op = ~b;
      o_bit_sel = ~s;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
endmodule // srb_core_model
`default_nettype wire

// *** test/srb_top_sva.sv ***
/*
 * port checker for the register bank, bound to every bank instance.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module srb_top_sva (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic        i_bit_op,
   input  wire logic [19:0] i_addr,
   input  wire logic        i_cause_pin,
   input  wire logic        i_cause_wdt,
   input  wire logic        i_cause_lvd,
   input  wire logic        i_opt_wdt_on,
   input  wire logic [23:0] i_irq_set,
   input  wire logic        o_ack,
   input  wire logic        o_err,
   input  wire logic [7:0]  o_rdata,
   input  wire logic        o_win_pri,
   input  wire logic        o_win_ext,
   input  wire logic [1:0]  o_extra_bytes,
   input  wire logic [23:0] o_irq_req,
   input  wire logic [23:0] o_irq_mask,
   input  wire logic [23:0] o_prio_lo,
   input  wire logic [23:0] o_prio_hi,
   input  wire logic [7:0]  o_clk_out_sel,
   input  wire logic [7:0]  o_proc_mode,
   input  wire logic [7:0]  o_wdt_enable,
   input  wire logic [7:0]  o_reset_cause
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // =====================================================
   // access answers and window decode
   AST_ACK_ONE: assert property (i_req |=> o_ack && $past(i_req))
      else $error("access not answered next cycle");
   AST_ACK_ONLY: assert property (!i_req |=> !o_ack)
      else $error("answer without a request");
   AST_EXT_WIN: assert property (i_req && i_addr >= srb_pkg::LP_EXT_LO &&
      i_addr <= srb_pkg::LP_EXT_HI |=> o_win_ext && o_err && o_extra_bytes == 2'h1)
      else $error("extended window decode wrong");
   AST_PRI_WIN: assert property (i_req && i_addr >= srb_pkg::LP_PRI_LO |=>
      o_win_pri && !o_win_ext && o_extra_bytes == 2'h0)
      else $error("primary window decode wrong");
   AST_WDT_BIT: assert property (i_req && i_bit_op && i_addr == srb_pkg::LP_A_WDTEN
      |=> o_err && o_rdata == 8'h00)
      else $error("bit access to watchdog enable not refused");
   AST_RC_RO: assert property (i_req && i_we && !i_bit_op &&
      i_addr == srb_pkg::LP_A_RCAUSE |=> !o_err && $stable(o_reset_cause))
      else $error("reset cause changed by a write");
   AST_IF_SET: assert property (i_irq_set[0] |=> o_irq_req[0])
      else $error("request event lost");

   // =====================================================
   // values seen at the edge that ends reset, and what that edge loads
   AST_RV_ZERO: assert property ($rose(i_rst_n) |-> o_irq_req == 24'h0 &&
      o_clk_out_sel == 8'h00 && o_proc_mode == 8'h00)
      else $error("zero reset values wrong");
   AST_RV_ONES: assert property ($rose(i_rst_n) |-> o_irq_mask == 24'hFFFFFF &&
      o_prio_lo == 24'hFFFFFF && o_prio_hi == 24'hFFFFFF)
      else $error("mask or priority reset values wrong");
   AST_WDT_LOAD: assert property ($rose(i_rst_n) |=>
      o_wdt_enable == ($past(i_opt_wdt_on) ? 8'h9A : 8'h1A))
      else $error("watchdog enable preset wrong");
   AST_RC_PIN: assert property ($rose(i_rst_n) && (i_cause_pin || i_cause_lvd) |=>
      o_reset_cause == 8'h00)
      else $error("reset cause not cleared");
   AST_RC_WDT: assert property ($rose(i_rst_n) && i_cause_wdt && !i_cause_pin &&
      !i_cause_lvd |=> o_reset_cause[srb_pkg::LP_RC_WDT])
      else $error("watchdog reset flag not set");
endmodule // srb_top_sva

bind srb_top srb_top_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
   .i_we(i_we), .i_bit_op(i_bit_op), .i_addr(i_addr), .i_cause_pin(i_cause_pin),
   .i_cause_wdt(i_cause_wdt), .i_cause_lvd(i_cause_lvd), .i_opt_wdt_on(i_opt_wdt_on),
   .i_irq_set(i_irq_set), .o_ack(o_ack), .o_err(o_err), .o_rdata(o_rdata),
   .o_win_pri(o_win_pri), .o_win_ext(o_win_ext), .o_extra_bytes(o_extra_bytes),
   .o_irq_req(o_irq_req), .o_irq_mask(o_irq_mask), .o_prio_lo(o_prio_lo),
   .o_prio_hi(o_prio_hi), .o_clk_out_sel(o_clk_out_sel), .o_proc_mode(o_proc_mode),
   .o_wdt_enable(o_wdt_enable), .o_reset_cause(o_reset_cause));
`default_nettype wire

// *** test/srb_top_tb_top.sv ***
/*
 * self-checking bench for the register bank with a core model as master.
 * assumes the checker is bound from its own file and compiled before this one.
 */
`timescale 1ns/10ps
`default_nettype none

module srb_top_tb_top;
   // =====================================================
   // signals and register table
   logic        clk = 1'h0;
   logic        rst_n, por_n, c_pin, c_ill, c_wdt, c_supply_monitor_reset, c_lvd, opt;
   logic        req, we, bop, ack, err, wp, wx, gerr, gack, err_s;
   logic [2:0]  bsel;
   logic [19:0] addr;
   logic [7:0]  wd, rd, rcause, rcx, got;
   wire logic [119:0] ov;   // register outputs, in the slot order of RA
   logic [1:0]  xb;
   logic [23:0] irq_set, s;
   logic [31:0] seed = 32'h794E;
   int          mismatches = 0;
   int          samples_checked = 0;
   localparam logic [19:0] RA [15] = '{srb_pkg::LP_A_CKS, srb_pkg::LP_A_WDTEN,
      srb_pkg::LP_A_IF_A_L, srb_pkg::LP_A_IF_A_H, srb_pkg::LP_A_IF_B_L, srb_pkg::LP_A_MK_A_L,
      srb_pkg::LP_A_MK_A_H, srb_pkg::LP_A_MK_B_L, srb_pkg::LP_A_PL_A_L, srb_pkg::LP_A_PL_A_H,
      srb_pkg::LP_A_PL_B_L, srb_pkg::LP_A_PH_A_L, srb_pkg::LP_A_PH_A_H, srb_pkg::LP_A_PH_B_L,
      srb_pkg::LP_A_PMC};
   localparam logic [7:0] RV [15] = '{8'h00, 8'h1A, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

   always #4 clk = ~clk;

   srb_core_model u_core (.i_clk(clk), .o_req(req), .o_we(we), .o_bit_op(bop),
      .o_bit_sel(bsel), .o_addr(addr), .o_wdata(wd), .i_ack(ack), .i_err(err), .i_rdata(rd));

   srb_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_req(req), .i_we(we),
      .i_bit_op(bop), .i_bit_sel(bsel), .i_addr(addr), .i_wdata(wd), .o_ack(ack),
      .o_err(err), .o_rdata(rd), .o_win_pri(wp), .o_win_ext(wx), .o_extra_bytes(xb),
      .i_cause_pin(c_pin), .i_cause_illegal(c_ill), .i_cause_wdt(c_wdt),
      .i_cause_supply_monitor_reset(c_supply_monitor_reset), .i_cause_lvd(c_lvd), .i_opt_wdt_on(opt), .i_irq_set(irq_set),
      .o_irq_req(ov[39:16]), .o_irq_mask(ov[63:40]), .o_prio_lo(ov[87:64]),
      .o_prio_hi(ov[111:88]), .o_clk_out_sel(ov[7:0]), .o_proc_mode(ov[119:112]),
      .o_wdt_enable(ov[15:8]), .o_reset_cause(rcause));

   // small variant on the same bus: group b addresses must be refused
   srb_top #(.P_LARGE_PINS(1'h0)) DUT_S (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
      .i_req(req), .i_we(we), .i_bit_op(bop), .i_bit_sel(bsel), .i_addr(addr), .i_wdata(wd),
      .o_ack(), .o_err(err_s), .o_rdata(), .o_win_pri(), .o_win_ext(), .o_extra_bytes(),
      .i_cause_pin(c_pin), .i_cause_illegal(c_ill), .i_cause_wdt(c_wdt),
      .i_cause_supply_monitor_reset(c_supply_monitor_reset), .i_cause_lvd(c_lvd), .i_opt_wdt_on(opt), .i_irq_set(irq_set),
      .o_irq_req(), .o_irq_mask(), .o_prio_lo(), .o_prio_hi(), .o_clk_out_sel(),
      .o_proc_mode(), .o_wdt_enable(), .o_reset_cause());

   // =====================================================
   // expectation helpers: xorshift source, reset-cause successor
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic [7:0] rc_next(input logic [7:0] o, input int k);
      case (k)
         1: return o | (8'h01 << srb_pkg::LP_RC_TRAP);
         2: return o | (8'h01 << srb_pkg::LP_RC_WDT);
         3: return o | (8'h01 << srb_pkg::LP_RC_SUPPLY_MONITOR_RESET);
         default: return 8'h00;
      endcase
   endfunction

   // =====================================================
   // compare, access and reset tasks
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task automatic acc(input logic w, input logic b, input logic [2:0] bs,
                      input logic [19:0] a, input logic [7:0] d);
      u_core.access(w, b, bs, a, d, got, gerr, gack);
      chk1(gack, 1'h1);
   endtask
   // kind: 0 pin, 1 illegal, 2 watchdog, 3 supply monitor, 4 retention voltage
   task automatic do_reset(input int k, input logic o, input logic p);
      @(negedge clk);
      {c_pin, c_ill, c_wdt, c_supply_monitor_reset, c_lvd} = {k == 0, k == 1, k == 2, k == 3, k == 4};
      opt = o;
      rst_n = 1'h0;
      por_n = p;
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      por_n = 1'h1;
      repeat (2) @(negedge clk);
      {c_pin, c_ill, c_wdt, c_supply_monitor_reset, c_lvd} = '0;
      rcx = rc_next(p ? rcx : 8'h00, k);
      chk8(rcause, rcx);
      chk8(ov[15:8], o ? 8'h9A : 8'h1A);
      acc(1'h0, 1'h0, 3'h0, srb_pkg::LP_A_RCAUSE, 8'h00);
      chk8(got, rcx);
   endtask
   task automatic stop_test();
      $display("samples_checked=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // =====================================================
   // watchdog against a hung run
   initial begin
      #(8 * 20000);
      mismatches++;
      stop_test();
   end

   // =====================================================
   // main sequence
   initial begin
      {rst_n, por_n, c_pin, c_ill, c_wdt, c_supply_monitor_reset, c_lvd, opt} = '0;
      irq_set = 24'h0;
      rcx = 8'h00;
      do_reset(0, 1'h0, 1'h0);
      // reset value, random byte readback, random bit write and read per register
      foreach (RA[i]) begin
         acc(1'h0, 1'h0, 3'h0, RA[i], 8'h00);
         chk8(got, RV[i]);
         seed = xs(seed);
         acc(1'h1, 1'h0, 3'h0, RA[i], seed[7:0]);
         acc(1'h0, 1'h0, 3'h0, RA[i], 8'h00);
         chk8(got, seed[7:0]);
         chk8(ov[8 * i +: 8], seed[7:0]);
         acc(1'h1, 1'h1, seed[10:8], RA[i], {7'h00, ~seed[seed[10:8]]});
         acc(1'h0, 1'h1, seed[10:8], RA[i], 8'h00);
         chk1(gerr, i == 1);
         chk8(got, (i == 1) ? 8'h00 : {7'h00, ~seed[seed[10:8]]});
      end
      // reset cause: write ignored, bit access refused
      acc(1'h1, 1'h0, 3'h0, srb_pkg::LP_A_RCAUSE, ~rcx);
      chk1(gerr, 1'h0);
      acc(1'h0, 1'h0, 3'h0, srb_pkg::LP_A_RCAUSE, 8'h00);
      chk8(got, rcx);
      acc(1'h0, 1'h1, 3'h3, srb_pkg::LP_A_RCAUSE, 8'h00);
      chk1(gerr, 1'h1);
      // window decode on random addresses and the first address past the window
      repeat (8) begin
         seed = xs(seed);
         acc(seed[12], 1'h0, 3'h0, srb_pkg::LP_EXT_LO + {9'h000, seed[10:0]}, seed[7:0]);
         chk1(wx, 1'h1);
         chk8({6'h00, xb}, {6'h00, srb_pkg::LP_EXT_EXTRA});
         acc(1'h0, 1'h0, 3'h0, srb_pkg::LP_PRI_LO + {12'h000, seed[20:13]}, 8'h00);
         chk1(wp, 1'h1);
         chk8({6'h00, xb}, 8'h00);
      end
      acc(1'h0, 1'h0, 3'h0, 20'hF0800, 8'h00);
      chk1(wx, 1'h0);
      acc(1'h0, 1'h0, 3'h0, srb_pkg::LP_A_IF_B_L, 8'h00);
      chk1(err_s, 1'h1);
      chk1(gerr, 1'h0);
      // hardware events set request flags after they were cleared
      for (int j = 0; j < 3; j++) acc(1'h1, 1'h0, 3'h0, RA[2 + j], 8'h00);
      s = seed[31:8] | 24'h000001;
      @(negedge clk);
      irq_set = s;
      @(negedge clk);
      irq_set = 24'h0;
      for (int j = 0; j < 3; j++) begin
         acc(1'h0, 1'h0, 3'h0, RA[2 + j], 8'h00);
         chk8(got, s[8 * j +: 8]);
      end
      // every reset source in turn, option bit random, cause flags accumulate until the retention-voltage and pin resets wipe them
      for (int k = 1; k < 6; k++) begin
         seed = xs(seed);
         do_reset(k % 5, seed[0], 1'h1);
      end
      stop_test();
   end
endmodule // srb_top_tb_top
`default_nettype wire
